// ### design/pic_controller.v
// Prioritized interrupt controller with pending latches and vector output
`include "pic_consts.vh"
`default_nettype none

// Operation
// R01: Nineteen sources besides reset; three priority levels shared by two sources.
// R02: Software, undefined, trap and watchdog accepted regardless of enables.
// R03: A request sets its latch; CPU asked only when source enabled.
// R04: Latch clears right after the CPU accepts that interrupt.
// R05: Reset clears every pending latch.
// R06: CPU write never sets a latch; zero clears, one keeps.
// R07: Latches appear as bytes at 003C and 003D, bitwise clearable.
// R08: Latch reads return current pending state.
// R09: Software clears with plain loads, writing one into trap and watchdog bits.
// R10: Software and undefined-instruction interrupts have no latch.
// R11: Simultaneous requests served by fixed priority, lower number wins; nesting allowed.
// R12: No relative priority among non-maskable sources, all level two.
// R13: Vectors: reset FFFE, software/undefined FFFC, trap FFFA, watchdog FFF8.
// R14: Levels 4 to 15 map to FFF6 down to FFE0, priorities 5-16.
// R15: Maskable needs master and individual enable; external zero also pin enable.
// R16: Select bits pick source at levels 10, 15, 16.
// R17: Software clears trap/watchdog output-select to use them as interrupts.
// R18: Software clears master enable around enable or latch changes.
// R19: Master enable reads zero on service entry, cleared by acceptance.
// R20: Acceptance stacks master enable then clears it; return restores it.
// R21: Unselected source at a shared level is not latched.
// R22: Low byte bits 1 and 0 read zero, writes ignored.
// R23: Present vector of best pending enabled request with valid flag.
module pic_controller (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // SFR port from the CPU core
  input  wire [7:0]  sfrAddr,
  input  wire        sfrWrite,
  input  wire        sfrRead,
  input  wire [7:0]  sfrWriteData,
  output reg  [7:0]  sfrReadData,
  // Interrupt sources (one-cycle pulses, same clock)
  input  wire        softwareIrq,
  input  wire        undefinedOpcodeIrq,
  input  wire        addressTrapIrq,
  input  wire        watchdogIrq,
  input  wire [8:0]  maskableIrq,
  input  wire        receiveDoneIrq,
  input  wire        serialIoIrq,
  input  wire        externalThreeIrq,
  input  wire        timerThreeIrq,
  input  wire        externalFiveIrq,
  input  wire        timerFiveIrq,
  // Pin function enable for external zero
  input  wire        ext0PinEnable,
  // CPU acceptance handshake
  input  wire        irqAccept,
  input  wire        returnFromIrqInstr,
  input  wire        stackedMasterEnable,
  // Request towards the CPU
  output reg         irqValid,
  output reg  [15:0] irqVector,
  output reg         masterIntEnableOut
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [15:0] pendingLatch_reg;
  reg  [15:0] pendingLatch_next;
  reg  [15:0] sourceEnableFlag_reg;
  reg  [7:0]  sharedSourceSelector_reg;
  reg         masterIntEnable_reg;
  reg         masterIntEnable_next;
  reg         softPending_reg;
  reg         softPending_next;
  reg  [1:0]  servedKind_reg;

  wire        level10Request;
  wire        level15Request;
  wire        level16Request;
  wire [15:0] setRequests;
  wire [15:0] maskableReady;
  wire        maskFound;
  wire [3:0]  maskWinner;
  reg         validNext;
  reg  [15:0] vectorNext;
  reg  [1:0]  kindNext;
  reg  [7:0]  readNext;

  localparam KIND_SOFT = 2'd0;
  localparam KIND_TRAP = 2'd1;
  localparam KIND_WDOG = 2'd2;
  localparam KIND_MASK = 2'd3;

  // ----------------------------------------------------------------
  // Source selection and request vector
  // ----------------------------------------------------------------
  pic_source_mux uMux (
    .receiveDoneIrq      (receiveDoneIrq),
    .serialIoIrq         (serialIoIrq),
    .externalThreeIrq    (externalThreeIrq),
    .timerThreeIrq       (timerThreeIrq),
    .externalFiveIrq     (externalFiveIrq),
    .timerFiveIrq        (timerFiveIrq),
    .level10SourceSelect (sharedSourceSelector_reg[`PIC_BIT_SEL_LEVEL10]),
    .level15SourceSelect (sharedSourceSelector_reg[`PIC_BIT_SEL_LEVEL15]),
    .level16SourceSelect (sharedSourceSelector_reg[`PIC_BIT_SEL_LEVEL16]),
    .level10Request      (level10Request),
    .level15Request      (level15Request),
    .level16Request      (level16Request)
  );

  // R01: nineteen sources
  // R10: no soft latch
  // Latch map: 2 trap, 3 watchdog, 8:4 and 13:10 plain, 9, 14, 15 shared
  // Bits 1:0 never receive a request, so they hold zero
  assign setRequests = {level16Request, level15Request, maskableIrq[8:5],
                        level10Request, maskableIrq[4:0], watchdogIrq,
                        addressTrapIrq, 2'b00};

  // R15: master and individual enables
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : gReady
      if (g < `PIC_LEVEL_FIRST_MASK) begin : gNmi
        assign maskableReady[g] = 1'b0;
      end else if (g == `PIC_LEVEL_FIRST_MASK) begin : gExt0
        assign maskableReady[g] = pendingLatch_reg[g] & sourceEnableFlag_reg[g]
                                  & masterIntEnable_reg & ext0PinEnable;
      end else begin : gMask
        assign maskableReady[g] = pendingLatch_reg[g] & sourceEnableFlag_reg[g]
                                  & masterIntEnable_reg;
      end
    end
  endgenerate

  // Priority scan over the maskable levels only
  pic_priority_encoder #(
    .LEVELS (16)
  ) uEnc (
    .requests (maskableReady),
    .found    (maskFound),
    .winner   (maskWinner)
  );

  // ----------------------------------------------------------------
  // Request selection towards the CPU
  // ----------------------------------------------------------------
  // R02: non-maskable ignore enables
  // R12: no order among them
  // All share level 2; a fixed scan is used only to pick one vector
  // R13: fixed vectors
  // R14: maskable vectors
  // R23: vector and valid
  // Idle shows the reset vector rather than a stale one
  always @* begin
    validNext  = 1'b0;
    kindNext   = KIND_SOFT;
    vectorNext = `PIC_VEC_RESET;
    if (softPending_reg) begin
      validNext  = 1'b1;
      kindNext   = KIND_SOFT;
      vectorNext = `PIC_VEC_SOFT;
    end else if (pendingLatch_reg[`PIC_LEVEL_TRAP]) begin
      validNext  = 1'b1;
      kindNext   = KIND_TRAP;
      vectorNext = `PIC_VEC_TRAP;
    end else if (pendingLatch_reg[`PIC_LEVEL_WDOG]) begin
      validNext  = 1'b1;
      kindNext   = KIND_WDOG;
      vectorNext = `PIC_VEC_WDOG;
    end else if (maskFound) begin
      validNext  = 1'b1;
      kindNext   = KIND_MASK;
      vectorNext = `PIC_VEC_MASK_BASE
                   - {11'd0, maskWinner - 4'd4, 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Latch and master enable update
  // ----------------------------------------------------------------
  // Acceptance refers to the request shown on the outputs in the same cycle
  always @* begin
    pendingLatch_next    = pendingLatch_reg;
    softPending_next     = softPending_reg;
    masterIntEnable_next = masterIntEnable_reg;
    // R06: zero clears, one keeps
    // R07: bitwise clear
    // R22: bits 1:0 ignored
    if (sfrWrite && sfrAddr == `PIC_ADDR_LATCH_LOW) begin
      pendingLatch_next[7:2] = pendingLatch_next[7:2] & sfrWriteData[7:2];
    end
    if (sfrWrite && sfrAddr == `PIC_ADDR_LATCH_HIGH) begin
      pendingLatch_next[15:8] = pendingLatch_next[15:8] & sfrWriteData;
    end
    if (sfrWrite && sfrAddr == `PIC_ADDR_ENABLE_LOW) begin
      masterIntEnable_next = sfrWriteData[`PIC_BIT_MASTER];
    end
    // R04: clear on acceptance
    // R20: stack and clear master
    // The core stacks the old value it sees on masterIntEnableOut
    if (irqAccept && irqValid) begin
      masterIntEnable_next = 1'b0;
      case (servedKind_reg)
        KIND_SOFT: softPending_next = 1'b0;
        KIND_TRAP: pendingLatch_next[`PIC_LEVEL_TRAP] = 1'b0;
        KIND_WDOG: pendingLatch_next[`PIC_LEVEL_WDOG] = 1'b0;
        KIND_MASK: pendingLatch_next[irqVectorLevel(irqVector)] = 1'b0;
        default:   softPending_next = softPending_reg;
      endcase
    end else if (returnFromIrqInstr) begin
      masterIntEnable_next = stackedMasterEnable;
    end
    // R03: request sets latch
    // A new event wins over any clear in the same cycle
    pendingLatch_next = pendingLatch_next | setRequests;
    if (softwareIrq || undefinedOpcodeIrq) begin
      softPending_next = 1'b1;
    end
  end

  // Level index from a maskable vector address
  // Decoding the shown vector ties the cleared latch to what was taken
  function [3:0] irqVectorLevel;
    input [15:0] vec;
    reg   [15:0] diff;
    begin
      diff           = `PIC_VEC_MASK_BASE - vec;
      irqVectorLevel = diff[4:1] + 4'd4;
    end
  endfunction

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  // R08: read pending state
  // Unmapped bytes read zero so no stale data leaks out
  always @* begin
    case (sfrAddr)
      `PIC_ADDR_LATCH_LOW:   readNext = {pendingLatch_reg[7:2], 2'b00};
      `PIC_ADDR_LATCH_HIGH:  readNext = pendingLatch_reg[15:8];
      `PIC_ADDR_ENABLE_LOW:  readNext = {sourceEnableFlag_reg[7:4], 3'b000, masterIntEnable_reg};
      `PIC_ADDR_ENABLE_HIGH: readNext = sourceEnableFlag_reg[15:8];
      `PIC_ADDR_SELECTOR:    readNext = sharedSourceSelector_reg;
      default:               readNext = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // R05: latches reset to zero
  // R19: master reads zero after acceptance
  // After reset the idle vector is the reset vector
  always @(posedge clk) begin
    if (reset) begin
      pendingLatch_reg         <= `PIC_LATCH_RESET;
      softPending_reg          <= 1'b0;
      masterIntEnable_reg      <= 1'b0;
      sourceEnableFlag_reg     <= `PIC_ENABLE_RESET;
      sharedSourceSelector_reg <= `PIC_SEL_RESET;
      servedKind_reg           <= KIND_SOFT;
      irqValid                 <= 1'b0;
      irqVector                <= `PIC_VEC_RESET;
      masterIntEnableOut       <= 1'b0;
      sfrReadData              <= 8'h00;
    end else begin
      pendingLatch_reg    <= pendingLatch_next;
      softPending_reg     <= softPending_next;
      masterIntEnable_reg <= masterIntEnable_next;
      masterIntEnableOut  <= masterIntEnable_next;
      // Unused selector bits read back zero
      // R16: select bits
      if (sfrWrite && sfrAddr == `PIC_ADDR_SELECTOR) begin
        sharedSourceSelector_reg <= sfrWriteData
                                    & 8'h43;
      end
      // Individual enables exist for levels 4 and up only
      if (sfrWrite && sfrAddr == `PIC_ADDR_ENABLE_LOW) begin
        sourceEnableFlag_reg[7:4] <= sfrWriteData[7:4];
      end
      if (sfrWrite && sfrAddr == `PIC_ADDR_ENABLE_HIGH) begin
        sourceEnableFlag_reg[15:8] <= sfrWriteData;
      end
      // Hide the request for one cycle after acceptance so stale state
      // never offers the same vector twice
      if (irqAccept && irqValid) begin
        irqValid <= 1'b0;
      end else begin
        irqValid       <= validNext;
        irqVector      <= vectorNext;
        servedKind_reg <= kindNext;
      end
      // Read data holds until the next read strobe
      if (sfrRead) begin
        sfrReadData <= readNext;
      end
    end
  end

endmodule
`default_nettype wire

// ### design/pic_consts.vh
// Constants for the prioritized interrupt controller
`ifndef PIC_CONSTS_VH
`define PIC_CONSTS_VH

// ----------------------------------------------------------------
// Register map (byte addresses on the SFR port)
// ----------------------------------------------------------------
`define PIC_ADDR_LATCH_LOW   8'h3C
`define PIC_ADDR_LATCH_HIGH  8'h3D
`define PIC_ADDR_ENABLE_LOW  8'h3A
`define PIC_ADDR_ENABLE_HIGH 8'h3B
`define PIC_ADDR_SELECTOR    8'h3E

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PIC_BIT_MASTER       0
`define PIC_BIT_SEL_LEVEL10  6
`define PIC_BIT_SEL_LEVEL15  1
`define PIC_BIT_SEL_LEVEL16  0
`define PIC_LEVEL_TRAP       2
`define PIC_LEVEL_WDOG       3
`define PIC_LEVEL_FIRST_MASK 4
`define PIC_LEVEL_SHARED10   9
`define PIC_LEVEL_SHARED15   14
`define PIC_LEVEL_SHARED16   15
`define PIC_LATCH_RESET      16'h0000
`define PIC_ENABLE_RESET     16'h0000
`define PIC_SEL_RESET        8'h00

// ----------------------------------------------------------------
// Vector addresses
// ----------------------------------------------------------------
`define PIC_VEC_RESET        16'hFFFE
`define PIC_VEC_SOFT         16'hFFFC
`define PIC_VEC_TRAP         16'hFFFA
`define PIC_VEC_WDOG         16'hFFF8
`define PIC_VEC_MASK_BASE    16'hFFF6

`endif

// ### design/pic_source_mux.v
// Shared-level source selection in front of the pending latches
`default_nettype none

module pic_source_mux (
  // Raw request pulses
  input  wire        receiveDoneIrq,
  input  wire        serialIoIrq,
  input  wire        externalThreeIrq,
  input  wire        timerThreeIrq,
  input  wire        externalFiveIrq,
  input  wire        timerFiveIrq,
  // Selector bits
  input  wire        level10SourceSelect,
  input  wire        level15SourceSelect,
  input  wire        level16SourceSelect,
  // Selected requests
  output wire        level10Request,
  output wire        level15Request,
  output wire        level16Request
);

  // R21: unselected dropped
  // The unselected source never reaches its latch, so it is not held
  assign level10Request = level10SourceSelect ? serialIoIrq   : receiveDoneIrq;
  assign level15Request = level15SourceSelect ? timerThreeIrq : externalThreeIrq;
  assign level16Request = level16SourceSelect ? timerFiveIrq  : externalFiveIrq;

endmodule
`default_nettype wire

// ### design/pic_priority_encoder.v
// Fixed-priority pick among pending and enabled maskable levels
`default_nettype none

module pic_priority_encoder #(
  parameter LEVELS = 16
) (
  // Requests per latch level
  input  wire [LEVELS-1:0] requests,
  // Winner
  output reg               found,
  output reg  [3:0]        winner
);

  integer i;

  // R11: lowest level wins
  // Scan from high to low so the lowest index is assigned last
  always @* begin
    found  = 1'b0;
    winner = 4'd0;
    for (i = LEVELS - 1; i >= 0; i = i - 1) begin
      if (requests[i]) begin
        found  = 1'b1;
        winner = i[3:0];
      end
    end
  end

endmodule
`default_nettype wire

// ### testbench/pic_controller_chk.sv
// Port-level assertions for the interrupt controller
`include "pic_consts.vh"
`default_nettype none
module pic_controller_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Register port
  input wire logic [7:0]  sfrAddr,
  input wire logic        sfrRead,
  input wire logic [7:0]  sfrReadData,
  // Sources and handshake
  input wire logic        softwareIrq,
  input wire logic        irqAccept,
  input wire logic        returnFromIrqInstr,
  input wire logic        stackedMasterEnable,
  // Request towards the CPU
  input wire logic        irqValid,
  input wire logic [15:0] irqVector,
  input wire logic        masterIntEnableOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rst;
    $fell(reset) |-> !irqValid && irqVector == 16'hFFFE && !masterIntEnableOut;
  endproperty
  property p_acc_drop;
    irqAccept && irqValid |=> !irqValid;
  endproperty
  property p_acc_imf;
    irqAccept && irqValid |=> !masterIntEnableOut;
  endproperty
  property p_ret;
    returnFromIrqInstr && !irqAccept |=> masterIntEnableOut == $past(stackedMasterEnable);
  endproperty
  property p_soft;
    softwareIrq && !irqAccept ##1 !irqAccept |=> irqValid && irqVector == 16'hFFFC;
  endproperty
  property p_vec;
    irqValid |-> irqVector[15:5] == 11'h7FF && !irqVector[0] && irqVector != 16'hFFFE;
  endproperty
  // Stale maskable vectors would slip past a cleared master enable
  property p_mask;
    (!masterIntEnableOut)[*3] ##0 irqValid |-> irqVector[15:3] == 13'h1FFF;
  endproperty
  property p_low_bits;
    sfrRead && sfrAddr == `PIC_ADDR_LATCH_LOW |=> sfrReadData[1:0] == 2'b00;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs wrong after reset");
  a_acc_drop: assert property (p_acc_drop) else $error("valid held after accept");
  a_acc_imf: assert property (p_acc_imf) else $error("master set after accept");
  a_ret: assert property (p_ret) else $error("master not restored");
  a_soft: assert property (p_soft) else $error("software vector missing");
  a_vec: assert property (p_vec) else $error("vector out of table");
  a_mask: assert property (p_mask) else $error("maskable shown while masked");
  a_low_bits: assert property (p_low_bits) else $error("low latch bits set");
  // Main scenarios reached
  c_trap: cover property (irqAccept && irqValid && irqVector == 16'hFFFA);
  c_ext0: cover property (irqAccept && irqValid && irqVector == 16'hFFF6);
  c_ret: cover property (returnFromIrqInstr);
endmodule
bind pic_controller pic_controller_chk i_chk (.clk, .reset, .sfrAddr, .sfrRead, .sfrReadData,
  .softwareIrq, .irqAccept, .returnFromIrqInstr, .stackedMasterEnable, .irqValid, .irqVector,
  .masterIntEnableOut);
`default_nettype wire

// ### testbench/pic_cpu_model.sv
// Behavioural CPU core that accepts requests and returns from service
`default_nettype none
module pic_cpu_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Request from the controller
  input  wire logic        irqValid,
  input  wire logic [15:0] irqVector,
  input  wire logic        masterIntEnableOut,
  // Bench control
  input  wire logic [3:0]  acceptDelay,
  input  wire logic        retReq,
  // Handshake back
  output var  logic        irqAccept,
  output var  logic        returnFromIrqInstr,
  output var  logic        stackedMasterEnable,
  output var  logic [15:0] lastVector,
  output var  int          acceptCount
);
  timeunit 1ns;
  timeprecision 1ps;
  int          waitCnt;
  logic        v, a, r, m;
  logic [15:0] vec;
  initial begin
    irqAccept = 1'b0;
    returnFromIrqInstr = 1'b0;
    stackedMasterEnable = 1'b0;
    lastVector = 16'h0000;
    acceptCount = 0;
    waitCnt = 0;
  end
  // Sample at the edge, answer a step later; slow answers need a delay
  always @(posedge clk) begin
    v = irqValid;
    a = irqAccept;
    r = retReq;
    m = masterIntEnableOut;
    vec = irqVector;
    #1;
    irqAccept = 1'b0;
    returnFromIrqInstr = r;
    if (reset) begin
      waitCnt = 0;
    end else if (a && v) begin
      stackedMasterEnable = m;
      lastVector = vec;
      acceptCount++;
      waitCnt = 0;
    end else if (v && waitCnt >= acceptDelay) begin
      irqAccept = 1'b1;
    end else if (v) begin
      waitCnt++;
    end
  end
endmodule
`default_nettype wire

// ### testbench/pic_controller_tb_top.sv
// Self-checking bench for the prioritized interrupt controller
`default_nettype none
module pic_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset, sfrWrite, sfrRead, ext0PinEnable, retReq, irqAccept;
  logic        returnFromIrqInstr, stackedMasterEnable, irqValid, masterIntEnableOut;
  logic [7:0]  sfrAddr, sfrWriteData, sfrReadData;
  logic [18:0] src;
  logic [3:0]  acceptDelay, m;
  logic [15:0] irqVector, lastVector;
  int          acceptCount, errors, num_checks, cyc, seed, q[$];
  // ----------------------------------------------------------------
  // Design and partner
  // ----------------------------------------------------------------
  pic_controller i_dut (.clk, .reset, .sfrAddr, .sfrWrite, .sfrRead, .sfrWriteData,
    .sfrReadData, .softwareIrq(src[18]), .undefinedOpcodeIrq(src[17]),
    .addressTrapIrq(src[16]), .watchdogIrq(src[15]), .maskableIrq(src[14:6]),
    .receiveDoneIrq(src[5]), .serialIoIrq(src[4]), .externalThreeIrq(src[3]),
    .timerThreeIrq(src[2]), .externalFiveIrq(src[1]), .timerFiveIrq(src[0]), .ext0PinEnable,
    .irqAccept, .returnFromIrqInstr, .stackedMasterEnable, .irqValid, .irqVector,
    .masterIntEnableOut);
  pic_cpu_model i_cpu (.clk, .reset, .irqValid, .irqVector, .masterIntEnableOut,
    .acceptDelay, .retReq, .irqAccept, .returnFromIrqInstr, .stackedMasterEnable,
    .lastVector, .acceptCount);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // One-cycle strobe; read data lands the cycle after
  task automatic sfr(input logic w, input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk) #1;
    sfrAddr = ad;
    sfrWriteData = d;
    sfrWrite = w;
    sfrRead = !w;
    @(posedge clk) #1;
    sfrWrite = 1'b0;
    sfrRead = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    sfr(1'b0, ad, 8'h00);
    chk($sformatf("read %h", ad), {8'h00, e}, {8'h00, sfrReadData});
  endtask
  task automatic pulse(input logic [18:0] v);
    @(posedge clk) #1 src = v;
    @(posedge clk) #1 src = 19'h0_0000;
  endtask
  // Bounded wait for the partner to take a request
  task automatic waitAcc(input logic [15:0] e);
    int c;
    c = acceptCount;
    for (int i = 0; i < 60 && acceptCount == c; i++) @(posedge clk);
    #2;
    chk("vector", e, lastVector);
  endtask
  task automatic ret();
    @(posedge clk) #1 retReq = 1'b1;
    @(posedge clk) #1 retReq = 1'b0;
    @(posedge clk) #2;
    chk("master restored", 16'h0001, {15'h0000, masterIntEnableOut});
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {reset, sfrWrite, sfrRead, ext0PinEnable, retReq} = 5'b10000;
    {sfrAddr, sfrWriteData, src, acceptDelay} = '0;
    seed = 32'h9154_172f;
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    rd(8'h3C, 8'h00);
    rd(8'h3D, 8'h00);
    chk("idle vector", 16'hFFFE, irqVector);
    // Non-maskable sources with the master enable still clear
    // output-selects taken as cleared: trap and watchdog arrive as interrupts
    acceptDelay = 4'h8;
    for (int i = 0; i < 4; i++) begin
      pulse(19'h4_0000 >> i);
      rd(8'h3C, i >= 2 ? 8'(8'h04 << (i - 2)) : 8'h00);
      waitAcc(i >= 2 ? 16'(16'hFFFA - 2 * (i - 2)) : 16'hFFFC);
      rd(8'h3C, 8'h00);
    end
    // Latch writes clear only; disabled source does not ask
    pulse(19'h0_0080);
    rd(8'h3C, 8'h20);
    chk("valid masked", 16'h0000, {15'h0000, irqValid});
    sfr(1'b1, 8'h3C, 8'hFF);
    rd(8'h3C, 8'h20);
    sfr(1'b1, 8'h3C, 8'hDF);
    rd(8'h3C, 8'h00);
    rd(8'h50, 8'h00);
    // Ninth plain maskable source lands in latch bit 13
    pulse(19'h0_4000);
    rd(8'h3D, 8'h20);
    sfr(1'b1, 8'h3D, 8'hDF);
    // Shared levels: only the selected source latches
    for (int s = 0; s < 2; s++) begin
      sfr(1'b1, 8'h3E, s ? 8'h43 : 8'h00);
      rd(8'h3E, s ? 8'h43 : 8'h00);
      pulse(s ? 19'h0_002A : 19'h0_0015);
      rd(8'h3D, 8'h00);
      pulse(s ? 19'h0_0015 : 19'h0_002A);
      rd(8'h3D, 8'hC2);
      sfr(1'b1, 8'h3D, 8'h00);
    end
    sfr(1'b1, 8'h3A, 8'hF0);
    sfr(1'b1, 8'h3A, 8'hF1);
    rd(8'h3A, 8'hF1);
    for (int r = 0; r < 4; r++) begin
      m = 4'($random(seed));
      if (m == 4'h0) m = 4'h1;
      ext0PinEnable = (r % 2 == 0);
      acceptDelay = 4'($random(seed) & 3);
      for (int b = 0; b < 4; b++) begin
        if (m[b] && (b > 0 || ext0PinEnable)) begin
          q.push_back(16'hFFF6 - 2 * b);
        end
      end
      pulse({9'h000, m, 6'h00});
      while (q.size() > 0) begin
        waitAcc(16'(q.pop_front()));
        chk("master in service", 16'h0000, {15'h0000, masterIntEnableOut});
        ret();
      end
      rd(8'h3C, {3'b000, m[0] && !ext0PinEnable, 4'h0});
      sfr(1'b1, 8'h3A, 8'hF0);
      sfr(1'b1, 8'h3C, 8'h0F);
      sfr(1'b1, 8'h3A, 8'hF1);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
